// File: logic/pimfb_pkg.sv
// Summary of operation
// - Two mask bits for the programmable timers share one address, bit 1 timer 1 and bit 0 timer 0, read/write, 1 enables, reset clears.
// - One read/write mask bit in bit 0 enables the serial interrupt when 1 and resets to 0.
// - One read/write mask bit in bit 0 enables the key input group interrupt when 1 and resets to 0.
// - Four read/write clock-timer mask bits (bit 3 1 Hz, bit 2 2 Hz, bit 1 8 Hz, bit 0 32 Hz) enable when 1 and reset to 0.
// - Two read/write stopwatch mask bits (bit 1 1 Hz, bit 0 10 Hz) enable when 1 and reset to 0.
// - The timer pending flags (bit 1 timer 1, bit 0 timer 0) read 1 after their event, clear on a written 1, ignore a written 0 and reset to 0.
// - The serial pending flag in bit 0 sets on its event, clears on a written 1, ignores a written 0 and resets to 0.
// - The key group pending flag in bit 0 sets on a key event, clears on a written 1, ignores a written 0 and resets to 0.
// - The four clock-timer pending flags set on their events, clear on a written 1, ignore a written 0 and reset to 0.
// - The two stopwatch pending flags set on their events, clear on a written 1, ignore a written 0 and reset to 0.
package pimfb_pkg;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 4;
	localparam int NUM_GRP = 5;
	localparam logic [15:0] OFS_TMR_EN = 16'hFFE2;
	localparam logic [15:0] OFS_SER_EN = 16'hFFE3;
	localparam logic [15:0] OFS_KEY_EN = 16'hFFE4;
	localparam logic [15:0] OFS_TICK_EN = 16'hFFE6;
	localparam logic [15:0] OFS_SW_EN = 16'hFFE7;
	localparam logic [15:0] OFS_TMR_PEND = 16'hFFF2;
	localparam logic [15:0] OFS_SER_PEND = 16'hFFF3;
	localparam logic [15:0] OFS_KEY_PEND = 16'hFFF4;
	localparam logic [15:0] OFS_TICK_PEND = 16'hFFF6;
	localparam logic [15:0] OFS_SW_PEND = 16'hFFF7;
	// Implemented-bit masks per group; everything else reads 0.
	localparam logic [3:0] MSK_TMR = 4'h3;
	localparam logic [3:0] MSK_SER = 4'h1;
	localparam logic [3:0] MSK_KEY = 4'h1;
	localparam logic [3:0] MSK_TICK = 4'hF;
	localparam logic [3:0] MSK_SW = 4'h3;
	localparam logic [3:0] RST_VAL = 4'h0;
	localparam logic [31:0] RD_ZERO = 32'h0000_0000;
	typedef struct packed {
		logic [1:0] tmr;
		logic ser;
		logic key;
		logic [3:0] tick;
		logic [1:0] sw;
	} pimfb_evt_type;
endpackage

// File: logic/pimfb_top.sv
`timescale 1ns/1ns
`default_nettype none
// Registers are 16-bit word indices taken from the printed offsets; each sits in one 32-bit
// word at byte address four times the index. Answers come one cycle after the request.
module pimfb_top (
	input wire logic clk,
	input wire logic srst,
	input wire logic [17:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire pimfb_pkg::pimfb_evt_type evt_in,
	output logic irq
);
	logic [3:0] en_ff [pimfb_pkg::NUM_GRP];
	logic [3:0] pend_ff [pimfb_pkg::NUM_GRP];
	logic [3:0] nxt_en [pimfb_pkg::NUM_GRP];
	logic [3:0] nxt_pend [pimfb_pkg::NUM_GRP];
	logic [31:0] rdata_ff;
	logic ack_ff;
	logic [3:0] grp_msk [pimfb_pkg::NUM_GRP];
	logic [3:0] grp_evt [pimfb_pkg::NUM_GRP];
	logic [15:0] grp_en_ofs [pimfb_pkg::NUM_GRP];
	logic [15:0] grp_pend_ofs [pimfb_pkg::NUM_GRP];
	logic [15:0] word_idx;
	logic req;
	logic wr_go;
	logic [3:0] wdata;
	logic [3:0] hit_en;
	logic [3:0] hit_pend;
	logic [4:0] sel_en;
	logic [4:0] sel_pend;
	logic [4:0] grp_irq;
	logic [3:0] rd_mux;

	// Events arrive from peripherals on this same clock, so they are not resynchronised.
	assign grp_evt[0] = {2'h0, evt_in.tmr};
	assign grp_evt[1] = {3'h0, evt_in.ser};
	assign grp_evt[2] = {3'h0, evt_in.key};
	assign grp_evt[3] = evt_in.tick;
	assign grp_evt[4] = {2'h0, evt_in.sw};
	assign grp_msk[0] = pimfb_pkg::MSK_TMR;
	assign grp_msk[1] = pimfb_pkg::MSK_SER;
	assign grp_msk[2] = pimfb_pkg::MSK_KEY;
	assign grp_msk[3] = pimfb_pkg::MSK_TICK;
	assign grp_msk[4] = pimfb_pkg::MSK_SW;
	assign grp_en_ofs[0] = pimfb_pkg::OFS_TMR_EN;
	assign grp_en_ofs[1] = pimfb_pkg::OFS_SER_EN;
	assign grp_en_ofs[2] = pimfb_pkg::OFS_KEY_EN;
	assign grp_en_ofs[3] = pimfb_pkg::OFS_TICK_EN;
	assign grp_en_ofs[4] = pimfb_pkg::OFS_SW_EN;
	assign grp_pend_ofs[0] = pimfb_pkg::OFS_TMR_PEND;
	assign grp_pend_ofs[1] = pimfb_pkg::OFS_SER_PEND;
	assign grp_pend_ofs[2] = pimfb_pkg::OFS_KEY_PEND;
	assign grp_pend_ofs[3] = pimfb_pkg::OFS_TICK_PEND;
	assign grp_pend_ofs[4] = pimfb_pkg::OFS_SW_PEND;

	assign word_idx = avs_address[17:2];
	// A new request is taken only on the cycle it first appears, never during the answer cycle.
	assign req = (avs_read | avs_write) & ~ack_ff;
	// A write lands only at the edge where waitrequest is seen low, so the master's view and the state agree.
	assign wr_go = avs_write & ack_ff & avs_byteenable[0];
	assign wdata = avs_writedata[3:0];

	genvar g;
	generate
		for (g = 0; g < pimfb_pkg::NUM_GRP; g++) begin : gen_grp
			assign sel_en[g] = (word_idx == grp_en_ofs[g]);
			assign sel_pend[g] = (word_idx == grp_pend_ofs[g]);
			assign nxt_en[g] = (wr_go & sel_en[g]) ? (wdata & grp_msk[g]) : en_ff[g];
			// A new event wins over a clear written in the same cycle, so no event is lost.
			assign nxt_pend[g] = ((pend_ff[g] & ~((wr_go & sel_pend[g]) ? wdata : 4'h0)) | grp_evt[g])
				& grp_msk[g];
			assign grp_irq[g] = |(pend_ff[g] & en_ff[g]);
			always_ff @(posedge clk) begin
				if (srst) begin
					en_ff[g] <= pimfb_pkg::RST_VAL;
					pend_ff[g] <= pimfb_pkg::RST_VAL;
				end else begin
					en_ff[g] <= nxt_en[g];
					pend_ff[g] <= nxt_pend[g];
				end
			end
		end
	endgenerate

	always_comb begin
		hit_en = 4'h0;
		hit_pend = 4'h0;
		for (int i = 0; i < pimfb_pkg::NUM_GRP; i++) begin
			hit_en = hit_en | (sel_en[i] ? en_ff[i] : 4'h0);
			hit_pend = hit_pend | (sel_pend[i] ? pend_ff[i] : 4'h0);
		end
	end
	// Unmapped addresses read zero and drop writes.
	assign rd_mux = hit_en | hit_pend;

	always_ff @(posedge clk) begin
		if (srst) begin
			ack_ff <= 1'b0;
			rdata_ff <= pimfb_pkg::RD_ZERO;
		end else begin
			ack_ff <= req;
			rdata_ff <= {28'h0000000, rd_mux};
		end
	end

	assign avs_waitrequest = (avs_read | avs_write) & ~ack_ff;
	assign avs_readdata = rdata_ff;
	assign irq = |grp_irq;
endmodule
`default_nettype wire

// File: verification/pimfb_chk_sva.sv
`timescale 1ns/1ns
`default_nettype none
module pimfb_chk (
	input wire logic clk,
	input wire logic srst,
	input wire logic [17:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire pimfb_pkg::pimfb_evt_type evt_in,
	input wire logic irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	wire req = avs_read | avs_write;
	wire rdone = avs_read & !avs_waitrequest;
	wire [15:0] idx = avs_address[17:2];
	sequence req_new;
		req && !$past(req);
	endsequence
	wait_first_a: assert property (req_new |-> avs_waitrequest) else $error("new request not stalled");
	wait_once_a: assert property (req && avs_waitrequest |=> !avs_waitrequest) else $error("stall too long");
	rd_high_a: assert property (rdone |-> avs_readdata[31:4] == 28'h0) else $error("upper read bits set");
	rd_gap_a: assert property (rdone && idx < 16'hFFE2 |-> avs_readdata == 32'h0) else $error("gap read not 0");
	two_bits_a: assert property (rdone && idx inside {16'hFFE2, 16'hFFF2, 16'hFFE7, 16'hFFF7}
		|-> avs_readdata[3:2] == 2'h0) else $error("unused bits set");
	one_bit_a: assert property (rdone && idx inside {16'hFFE3, 16'hFFE4, 16'hFFF3, 16'hFFF4}
		|-> avs_readdata[3:1] == 3'h0) else $error("unused bits set");
	irq_fall_a: assert property (irq && !avs_write |=> irq) else $error("irq dropped without write");
	irq_rise_a: assert property (!irq && evt_in == 10'h000 && !avs_write |=> !irq) else $error("irq rose");
endmodule
bind pimfb_top pimfb_chk pimfb_chk_i (.clk, .srst, .avs_address, .avs_read, .avs_write, .avs_writedata,
	.avs_byteenable, .avs_readdata, .avs_waitrequest, .evt_in, .irq);
`default_nettype wire

// File: verification/pimfb_top_tb.sv
`timescale 1ns/1ns
`default_nettype none
module pimfb_top_tb;
	logic clk = 1'h0, srst = 1'h1, avs_read = 1'h0, avs_write = 1'h0, irq, avs_waitrequest;
	logic [17:0] avs_address = 18'h0;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
	logic [3:0] avs_byteenable = 4'hF;
	pimfb_pkg::pimfb_evt_type evt_in = 10'h000;
	int fails = 0, total_checks = 0;
	logic [15:0] ea[5] = '{16'hFFE2, 16'hFFE3, 16'hFFE4, 16'hFFE6, 16'hFFE7};
	logic [3:0] mk[5] = '{4'h3, 4'h1, 4'h1, 4'hF, 4'h3};
	pimfb_top pimfb_top_i (.clk, .srst, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_byteenable, .avs_readdata, .avs_waitrequest, .evt_in, .irq);
	initial forever #20 clk = ~clk;
	task chk(input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e) begin
			fails++;
			$display("mismatch at %0t: saw %h want %h", $time, s, e);
		end
	endtask
	// Holds the request until waitrequest is seen low, so no slave latency is assumed.
	task bus(input logic w, input logic [15:0] a, input logic [3:0] d);
		@(posedge clk);
		avs_address <= {a, 2'h0};
		avs_writedata <= {28'h0, d};
		avs_read <= !w;
		avs_write <= w;
		do begin
			@(posedge clk);
		end while (avs_waitrequest !== 1'h0);
		q = avs_readdata;
		avs_read <= 1'h0;
		avs_write <= 1'h0;
	endtask
	task pulse(input logic [9:0] v);
		@(posedge clk);
		evt_in <= v;
		@(posedge clk);
		evt_in <= 10'h000;
		// The flags load at the edge above, so let one edge pass before irq is looked at.
		@(posedge clk);
	endtask
	task t_reset;
		for (int i = 0; i < 5; i++) begin
			bus(1'h0, ea[i], 4'h0);
			chk(q, 32'h0);
			bus(1'h0, ea[i] + 16'h10, 4'h0);
			chk(q, 32'h0);
		end
		bus(1'h0, 16'hFFE5, 4'h0);
		chk(q, 32'h0);
	endtask
	task t_flags(input logic [3:0] en);
		for (int i = 0; i < 5; i++) bus(1'h1, ea[i], en);
		pulse(10'h3FF);
		chk(irq, {31'h0, en != 4'h0});
		for (int i = 0; i < 5; i++) begin
			bus(1'h0, ea[i], 4'h0);
			chk(q, {28'h0, mk[i] & en});
			bus(1'h1, ea[i] + 16'h10, 4'h0);
			bus(1'h0, ea[i] + 16'h10, 4'h0);
			chk(q, {28'h0, mk[i]});
			bus(1'h1, ea[i] + 16'h10, 4'hF);
			bus(1'h0, ea[i] + 16'h10, 4'h0);
			chk(q, 32'h0);
		end
		chk(irq, 32'h0);
	endtask
	task complete_run;
		$display("checks %0d fails %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge clk);
		srst <= 1'h0;
		t_reset;
		t_flags(4'hF);
		t_flags(4'h0);
		complete_run;
	end
	initial begin
		#100000;
		fails++;
		complete_run;
	end
endmodule
`default_nettype wire
